/* File: core/page_stream_load_receiver.sv */
// Page-stream load receiver: LPC cycle decoder and ready/busy control
`timescale 1ns/1ps
`default_nettype none
`include "page_stream_params.svh"

module page_stream_load_receiver
  import page_stream_pkg::*;
#(
  parameter int GROUP_BYTES = `GROUP_BYTES_DEF,
  parameter int GROUP_CYCLES = `GROUP_PROG_CYCLES,
  parameter int PAGE_CYCLES = `PAGE_PROG_CYCLES
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic lclk_i,
  input wire logic lframe_n_i,
  input wire logic [3:0] lad_i,
  input wire logic load_active_n_i,
  input wire logic supervoltage_enable_pin_i,
  input wire logic [3:0] chip_select_straps_i,
  input wire logic [6:0] read_offset_i,
  output logic ready_busy_n_o,
  output logic [13:0] page_address_o,
  output logic [7:0] program_count_o,
  output logic program_done_o,
  output logic [7:0] read_data_o
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [11:0] pin_meta_reg;
  logic [11:0] pin_sync_reg;
  logic lclk_prev_reg;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_meta_reg <= 12'h000;
      pin_sync_reg <= 12'h000;
      lclk_prev_reg <= 1'b0;
    end else begin
      pin_meta_reg <= {lclk_i, lframe_n_i, lad_i, load_active_n_i,
                       supervoltage_enable_pin_i, chip_select_straps_i};
      pin_sync_reg <= pin_meta_reg;
      lclk_prev_reg <= pin_sync_reg[11];
    end
  end

  logic lclk_s;
  logic frame_n_s;
  logic [3:0] lad_s;
  logic ld_n_s;
  logic hv_s;
  logic [3:0] straps_s;
  logic lclk_rise;

  assign lclk_s = pin_sync_reg[11];
  assign frame_n_s = pin_sync_reg[10];
  assign lad_s = pin_sync_reg[9:6];
  assign ld_n_s = pin_sync_reg[5];
  assign hv_s = pin_sync_reg[4];
  assign straps_s = pin_sync_reg[3:0];
  assign lclk_rise = lclk_s & ~lclk_prev_reg;

  // ----------------------------------------
  // Cycle decoder
  // ----------------------------------------
  page_buffer_if pb ();

  rx_state_t state_reg, state_next;
  logic [2:0] nib_cnt_reg, nib_cnt_next;
  logic [27:0] addr_reg, addr_next;
  logic [7:0] offset_reg, offset_next;
  logic [3:0] low_nib_reg, low_nib_next;
  logic half_reg, half_next;
  logic ready_reg, ready_next;
  logic wr_en_reg, wr_en_next;
  logic [6:0] wr_off_reg, wr_off_next;
  logic [7:0] wr_data_reg, wr_data_next;
  logic commit_reg, commit_next;
  logic final_reg, final_next;
  logic [7:0] count_reg, count_next;
  logic [7:0] offset_inc;

  assign offset_inc = offset_reg + 8'h01;

  always_comb begin
    state_next = state_reg;
    nib_cnt_next = nib_cnt_reg;
    addr_next = addr_reg;
    offset_next = offset_reg;
    low_nib_next = low_nib_reg;
    half_next = half_reg;
    wr_en_next = 1'b0;
    wr_off_next = wr_off_reg;
    wr_data_next = wr_data_reg;
    commit_next = 1'b0;
    final_next = 1'b0;
    count_next = count_reg;
    unique case (state_reg)
      ST_IDLE, ST_SEL: begin
        if (lclk_rise) begin
          if (!frame_n_s) begin
            // Latest start nibble while frame is low decides
            if (lad_s == `START_CODE && hv_s) begin
              state_next = ST_SEL;
            end else begin
              state_next = ST_IDLE;
            end
          end else if (state_reg == ST_SEL) begin
            if (lad_s == straps_s) begin
              state_next = ST_ADDR;
              nib_cnt_next = 3'h0;
            end else begin
              state_next = ST_IDLE;
            end
          end
        end
      end
      ST_ADDR: begin
        if (lclk_rise) begin
          addr_next = {addr_reg[23:0], lad_s};
          nib_cnt_next = nib_cnt_reg + 3'h1;
          if (nib_cnt_reg == `ADDR_LAST_NIBBLE) begin
            state_next = ST_SIZE;
          end
        end
      end
      ST_SIZE: begin
        if (lclk_rise) begin
          state_next = ST_DATA;
          offset_next = 8'h00;
          half_next = 1'b0;
        end
      end
      ST_DATA: begin
        if (ld_n_s) begin
          // Early end: a pending low nibble is dropped
          final_next = 1'b1;
          count_next = offset_reg;
          half_next = 1'b0;
          state_next = ST_PROG;
        end else if (lclk_rise && ready_reg) begin
          if (!half_reg) begin
            low_nib_next = lad_s;
            half_next = 1'b1;
          end else begin
            wr_en_next = 1'b1;
            wr_data_next = {lad_s, low_nib_reg};
            wr_off_next = offset_reg[6:0];
            offset_next = offset_inc;
            half_next = 1'b0;
            if (offset_reg == `LAST_OFFSET) begin
              final_next = 1'b1;
              count_next = offset_inc;
              state_next = ST_PROG;
            end else if ((int'(offset_inc) % GROUP_BYTES) == 0) begin
              commit_next = 1'b1;
            end
          end
        end
      end
      ST_PROG: begin
        if (!pb.busy && !final_reg) begin
          state_next = ST_IDLE;
        end
      end
    endcase
    // Busy while a group drains or the page programs
    ready_next = !(state_next == ST_PROG || commit_next || commit_reg || pb.busy);
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= ST_IDLE;
      nib_cnt_reg <= 3'h0;
      addr_reg <= 28'h0000000;
      offset_reg <= 8'h00;
      low_nib_reg <= 4'h0;
      half_reg <= 1'b0;
      ready_reg <= 1'b1;
      wr_en_reg <= 1'b0;
      wr_off_reg <= 7'h00;
      wr_data_reg <= 8'h00;
      commit_reg <= 1'b0;
      final_reg <= 1'b0;
      count_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      nib_cnt_reg <= nib_cnt_next;
      addr_reg <= addr_next;
      offset_reg <= offset_next;
      low_nib_reg <= low_nib_next;
      half_reg <= half_next;
      ready_reg <= ready_next;
      wr_en_reg <= wr_en_next;
      wr_off_reg <= wr_off_next;
      wr_data_reg <= wr_data_next;
      commit_reg <= commit_next;
      final_reg <= final_next;
      count_reg <= count_next;
    end
  end

  assign pb.wr_en = wr_en_reg;
  assign pb.wr_offset = wr_off_reg;
  assign pb.wr_data = wr_data_reg;
  assign pb.commit = commit_reg;
  assign pb.final_req = final_reg;
  assign pb.page = addr_reg[`PAGE_MSB:`PAGE_LSB];
  assign pb.count = count_reg;
  assign ready_busy_n_o = ready_reg;

  // ----------------------------------------
  // Page buffer
  // ----------------------------------------
  page_buffer #(
    .GROUP_CYCLES(GROUP_CYCLES),
    .PAGE_CYCLES(PAGE_CYCLES)
  ) u_buffer (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .pb(pb),
    .read_offset_i(read_offset_i),
    .page_address_o(page_address_o),
    .program_count_o(program_count_o),
    .program_done_o(program_done_o),
    .read_data_o(read_data_o)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  AST_START_RECOGNISED: assert property (
    (state_reg != ST_SEL && state_next == ST_SEL)
      |-> (lclk_rise && !frame_n_s && lad_s == `START_CODE && hv_s))
    else $error("Start taken without valid start field");
  AST_LAST_START_WINS: assert property (
    (state_reg == ST_SEL && lclk_rise && !frame_n_s && lad_s != `START_CODE)
      |=> state_reg == ST_IDLE)
    else $error("Superseded start field still honoured");
  AST_NO_HV_NO_CYCLE: assert property (
    (state_reg == ST_IDLE && !hv_s) |=> state_reg == ST_IDLE)
    else $error("Cycle started without supervoltage enable");
  AST_SELECT_MATCH: assert property (
    (state_reg == ST_SEL && state_next == ST_ADDR) |-> lad_s == straps_s)
    else $error("Address phase entered on select mismatch");
  AST_SEVEN_NIBBLES: assert property (
    state_reg == ST_SIZE |-> nib_cnt_reg == `ADDR_NIBBLES)
    else $error("Address phase not seven nibbles");
  AST_SIZE_IGNORED: assert property (
    (state_reg == ST_SIZE && lclk_rise) |=> state_reg == ST_DATA && offset_reg == 8'h00)
    else $error("Size nibble not skipped");
  AST_NO_TAKE_WHEN_BLOCKED: assert property (
    (!ready_reg || ld_n_s) |=> !wr_en_reg)
    else $error("Byte accepted while busy or load inactive");
  AST_LAST_BYTE_ENDS: assert property (
    (wr_en_reg && wr_off_reg == 7'h7f) |-> state_reg == ST_PROG && final_reg)
    else $error("Page did not close after byte 127");
  AST_OFFSET_STEPS: assert property (
    wr_en_reg |-> offset_reg == ({1'b0, wr_off_reg} + 8'h01))
    else $error("Byte offset did not advance by one");
  AST_EARLY_END: assert property (
    (state_reg == ST_DATA && ld_n_s) |=> final_reg && count_reg == $past(offset_reg))
    else $error("Partial load count wrong");
  AST_BUSY_ON_COMMIT: assert property (
    commit_reg |-> !ready_busy_n_o ##1 !ready_busy_n_o)
    else $error("Ready while group drains");
  AST_BUSY_IN_PROG: assert property (
    state_reg == ST_PROG |-> !ready_busy_n_o)
    else $error("Ready asserted during page programming");
endmodule

`default_nettype wire

/* File: core/page_stream_params.svh */
// Constants for the page-stream load receiver
// How it works
// - Respond only to frame-low start code 1110
// - Last start field before frame rises wins
// - Device select nibble must equal strapped pins
// - Seven address nibbles, most significant first
// - Only address bits 20 to 7 matter
// - Size nibble in clock ten ignored
// - Up to 128 bytes, low nibble first
// - Take nibbles only when ready and load low
// - Cycle recognised only with supervoltage enable high
// - Page aligned, writing starts at byte zero
// - Busy when buffer full, ready for next group
// - Early load end programs whole bytes only
// - Busy until page programmed, then idle ready
`ifndef PAGE_STREAM_PARAMS_SVH
`define PAGE_STREAM_PARAMS_SVH

`define START_CODE 4'he
`define ADDR_LAST_NIBBLE 3'h6
`define ADDR_NIBBLES 3'h7
`define PAGE_BYTES 128
`define PAGE_LSB 7
`define PAGE_MSB 20
`define LAST_OFFSET 8'h7f
`define GROUP_BYTES_DEF 16
`define CLK_PERIOD_PS 5000
`define GROUP_PROG_NS 100
`define PAGE_PROG_NS 1000
`define GROUP_PROG_CYCLES ((`GROUP_PROG_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define PAGE_PROG_CYCLES ((`PAGE_PROG_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

/* File: core/page_stream_pkg.sv */
// Types for the page-stream load receiver
package page_stream_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEL,
    ST_ADDR,
    ST_SIZE,
    ST_DATA,
    ST_PROG
  } rx_state_t;

  typedef logic [7:0] byte_t;

endpackage

/* File: core/page_buffer_if.sv */
// Link between the cycle decoder and the page buffer
`timescale 1ns/1ps
`default_nettype none

interface page_buffer_if;
  logic wr_en;
  logic [6:0] wr_offset;
  logic [7:0] wr_data;
  logic commit;
  logic final_req;
  logic [13:0] page;
  logic [7:0] count;
  logic busy;

  modport rx (output wr_en, wr_offset, wr_data, commit, final_req, page, count, input busy);
  modport buffer (input wr_en, wr_offset, wr_data, commit, final_req, page, count, output busy);
endinterface

`default_nettype wire

/* File: core/page_buffer.sv */
// Page buffer with group drain and page programming timers
`timescale 1ns/1ps
`default_nettype none
`include "page_stream_params.svh"

module page_buffer
  import page_stream_pkg::*;
#(
  parameter int GROUP_CYCLES = `GROUP_PROG_CYCLES,
  parameter int PAGE_CYCLES = `PAGE_PROG_CYCLES
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  page_buffer_if.buffer pb,
  input wire logic [6:0] read_offset_i,
  output logic [13:0] page_address_o,
  output logic [7:0] program_count_o,
  output logic program_done_o,
  output logic [7:0] read_data_o
);

  byte_t mem [`PAGE_BYTES];
  logic busy_reg, busy_next;
  logic page_mode_reg, page_mode_next;
  logic [15:0] timer_reg, timer_next;
  logic [13:0] page_reg, page_next;
  logic [7:0] count_reg, count_next;
  logic done_reg, done_next;

  // ----------------------------------------
  // Timers
  // ----------------------------------------
  always_comb begin
    busy_next = busy_reg;
    page_mode_next = page_mode_reg;
    timer_next = timer_reg;
    page_next = page_reg;
    count_next = count_reg;
    done_next = 1'b0;
    if (pb.commit) begin
      busy_next = 1'b1;
      page_mode_next = 1'b0;
      timer_next = 16'(GROUP_CYCLES - 1);
    end else if (pb.final_req) begin
      busy_next = 1'b1;
      page_mode_next = 1'b1;
      timer_next = 16'(PAGE_CYCLES - 1);
      page_next = pb.page;
      count_next = pb.count;
    end else if (busy_reg) begin
      if (timer_reg == 16'h0000) begin
        busy_next = 1'b0;
        done_next = page_mode_reg;
      end else begin
        timer_next = timer_reg - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_reg <= 1'b0;
      page_mode_reg <= 1'b0;
      timer_reg <= 16'h0000;
      page_reg <= 14'h0000;
      count_reg <= 8'h00;
      done_reg <= 1'b0;
      read_data_o <= 8'h00;
    end else begin
      busy_reg <= busy_next;
      page_mode_reg <= page_mode_next;
      timer_reg <= timer_next;
      page_reg <= page_next;
      count_reg <= count_next;
      done_reg <= done_next;
      read_data_o <= mem[read_offset_i];
    end
  end

  always_ff @(posedge clk_i) begin
    if (pb.wr_en) begin
      mem[pb.wr_offset] <= pb.wr_data;
    end
  end

  assign pb.busy = busy_reg;
  assign page_address_o = page_reg;
  assign program_count_o = count_reg;
  assign program_done_o = done_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  AST_GROUP_DRAIN_BUSY: assert property (
    pb.commit |=> busy_reg && !page_mode_reg && timer_reg == 16'(GROUP_CYCLES - 1))
    else $error("Busy did not start a full group drain after commit");
  AST_DRAIN_HOLDS: assert property (
    (busy_reg && timer_reg != 16'h0000 && !pb.commit && !pb.final_req)
      |=> busy_reg && timer_reg == $past(timer_reg) - 16'h0001)
    else $error("Busy dropped before its timer ran out");
  AST_PAGE_LATCHED: assert property (
    pb.final_req |=> page_address_o == $past(pb.page) && busy_reg)
    else $error("Page address not latched at program start");
endmodule

`default_nettype wire

/* File: test/page_stream_host.sv */
// Programming host model driving the LPC pins
`timescale 1ns/1ps
`default_nettype none

module page_stream_host (
  input wire logic clk_i,
  input wire logic ready_busy_n_i,
  output logic lclk_o,
  output logic lframe_n_o,
  output logic [3:0] lad_o,
  output logic load_active_n_o
);
  // ----------------
  // Pin drivers
  // ----------------
  initial begin
    lclk_o = 1'b0;
    lframe_n_o = 1'b1;
    lad_o = 4'h5;
    load_active_n_o = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // One nibble, clock parked low while busy
  task automatic nib(input logic [3:0] v, input logic fr);
    int k;
    lad_o = v;
    lframe_n_o = fr;
    tick(4);
    k = 0;
    while (ready_busy_n_i !== 1'b1 && k < 1000) begin
      tick(1);
      k++;
    end
    lclk_o = 1'b1;
    tick(4);
    lclk_o = 1'b0;
    tick(4);
  endtask

  // Whole load cycle
  task automatic cycle(input logic [3:0] s0, s1, sel, input logic [27:0] a,
                       input int nb, half, input logic [7:0] seed);
    logic [7:0] d;
    load_active_n_o = 1'b0;
    nib(s0, 1'b0);
    nib(s1, 1'b0);
    nib(sel, 1'b1);
    for (int i = 6; i >= 0; i--) begin
      nib(a[i*4 +: 4], 1'b1);
    end
    nib(4'h9, 1'b1);
    for (int i = 0; i < nb; i++) begin
      d = 8'(i * 7) + seed;
      nib(d[3:0], 1'b1);
      nib(d[7:4], 1'b1);
    end
    if (half != 0) begin
      nib(4'hc, 1'b1);
    end
    if (nb < 128) begin
      load_active_n_o = 1'b1;
    end
    lad_o = ~lad_o;
  endtask
endmodule

`default_nettype wire

/* File: test/page_stream_load_receiver_test.sv */
// Self-checking bench for the page-stream load receiver
`timescale 1ns/1ps
`default_nettype none

module page_stream_load_receiver_test;
  logic clk, resetn, sv_en, lclk, lframe_n, load_n, ready, done, ready_q;
  logic [3:0] lad, straps;
  logic [6:0] rd_off;
  logic [13:0] page_addr;
  logic [7:0] count, rd_data;
  int err_count = 0;
  int n_compared = 0;
  int n_done = 0;
  int n_fall = 0;
  int cycles = 0;
  int n0, f0;

  // ----------------
  // Design and host
  // ----------------
  page_stream_load_receiver #(.GROUP_BYTES(16), .GROUP_CYCLES(20), .PAGE_CYCLES(5)) dut (
    .clk_i(clk), .resetn_i(resetn), .lclk_i(lclk), .lframe_n_i(lframe_n),
    .lad_i(lad), .load_active_n_i(load_n), .supervoltage_enable_pin_i(sv_en),
    .chip_select_straps_i(straps), .read_offset_i(rd_off), .ready_busy_n_o(ready),
    .page_address_o(page_addr), .program_count_o(count), .program_done_o(done),
    .read_data_o(rd_data)
  );

  page_stream_host host (
    .clk_i(clk), .ready_busy_n_i(ready), .lclk_o(lclk), .lframe_n_o(lframe_n),
    .lad_o(lad), .load_active_n_o(load_n)
  );

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  // ----------------
  // Monitor and helpers
  // ----------------
  always @(posedge clk) begin
    cycles++;
    ready_q <= ready;
    if (done === 1'b1) n_done++;
    if (ready_q === 1'b1 && ready === 1'b0) n_fall++;
    if (cycles == 20000) begin
      err_count++;
      final_report();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input string name, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic rd(input int off, input logic [7:0] exp);
    rd_off = 7'(off);
    tick(2);
    check("read_data", 32'(rd_data), 32'(exp));
  endtask

  task automatic run(input logic [3:0] s0, s1, sel, input logic [27:0] a,
                     input int nb, half, input logic [7:0] seed, input int exp);
    n0 = n_done;
    f0 = n_fall;
    host.cycle(s0, s1, sel, a, nb, half, seed);
    for (int k = 0; k < 300 && n_done == n0; k++) tick(1);
    tick(3);
    check("done_pulses", 32'(n_done - n0), 32'(exp));
    check("ready_after", 32'(ready), 32'h1);
  endtask

  // ----------------
  // Scenarios
  // ----------------
  task automatic t_reset;
    check("ready", 32'(ready), 32'h1);
    check("page", 32'(page_addr), 32'h0);
    check("count", 32'(count), 32'h0);
    check("done", 32'(done), 32'h0);
  endtask

  task automatic t_full;
    logic [27:0] a;
    a = 28'hf3a5c77;
    run(4'he, 4'he, 4'ha, a, 128, 0, 8'h11, 1);
    check("falls", 32'(n_fall - f0), 32'h8);
    check("page", 32'(page_addr), 32'(a[20:7]));
    check("count", 32'(count), 32'h80);
    for (int i = 0; i < 128; i++) rd(i, 8'(i * 7) + 8'h11);
  endtask

  task automatic t_partial;
    logic [27:0] a;
    a = 28'h0012345;
    run(4'h2, 4'he, 4'ha, a, 5, 1, 8'h40, 1);
    check("falls", 32'(n_fall - f0), 32'h1);
    check("page", 32'(page_addr), 32'(a[20:7]));
    check("count", 32'(count), 32'h5);
    for (int i = 0; i < 5; i++) rd(i, 8'(i * 7) + 8'h40);
    rd(5, 8'(5 * 7) + 8'h11);
  endtask

  task automatic t_refuse;
    logic [3:0] s1 [3] = '{4'h2, 4'he, 4'he};
    logic [3:0] sel [3] = '{4'ha, 4'h5, 4'ha};
    logic sv [3] = '{1'b1, 1'b1, 1'b0};
    for (int c = 0; c < 3; c++) begin
      sv_en = sv[c];
      run(4'he, s1[c], sel[c], 28'h0000080, 3, 0, 8'h77, 0);
      check("falls", 32'(n_fall - f0), 32'h0);
      check("count", 32'(count), 32'h5);
      rd(0, 8'h40);
    end
    sv_en = 1'b1;
  endtask

  // ----------------
  // Main sequence
  // ----------------
  initial begin
    resetn = 1'b0;
    sv_en = 1'b1;
    straps = 4'ha;
    rd_off = 7'h0;
    tick(6);
    t_reset();
    resetn = 1'b1;
    tick(3);
    t_full();
    t_partial();
    t_refuse();
    final_report();
  end

  task automatic final_report;
    if (err_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
endmodule

`default_nettype wire
